// file: design/cc_calendar_clock.sv
// Serial calendar clock behind bit 8 of the additional status register.
`timescale 1ns/1ps
// Functional notes
// R1: Software reads the status register first; that read clears the pointer.
// R2: Access opens after 64 consecutive writes matching the pattern.
// R3: Every pattern and data bit passes through register bit 8.
// R4: Pattern goes bit 0 of word one to bit 15 of word four.
// R5: Pattern words are octal 035305, 056243, 035305, 056243.
// R6: Each write is compared with the pointed bit; a match advances it.
// R7: A mismatch freezes the pointer and later writes are ignored.
// R8: A read during recognition aborts it and resets the pointer.
// R9: After recognition the next 64 cycles move calendar bits.
// R10: Eight byte registers, bit 0 of register 0 to bit 7 of 7.
// R11: Registers are updated as whole bytes; stray bits may corrupt.
// R12: Register 0 holds hundredths, BCD 00 to 99.
// R13: Register 1 holds seconds, BCD 00 to 59, bit 7 zero.
// R14: Register 2 holds minutes, BCD 00 to 59, bit 7 zero.
// R15: Register 3 holds hours, 24-hour BCD 00 to 23.
// R16: Register 4 holds day of week 1 to 7.
// R17: Register 5 holds day of month, BCD 01 to 31.
// R18: Register 6 holds month, BCD 01 to 12.
// R19: Register 7 holds year, BCD 00 to 99.
// R20: Short months and leap-year February end automatically.
// R21: In a data read the current bit appears on bit 8.
// R22: After 64 data cycles the port returns to unrecognised.
module cc_calendar_clock
   import cc_pkg::*;
#(
   parameter int TICK_CYCLES = CC_TICK_CYCLES
) (
   input  wire logic CLK,
   input  wire logic SYS_RST,
   input  wire logic ASR_RD_STB,
   input  wire logic ASR_WR_STB,
   input  wire logic ASR_WR_BIT8,
   output logic      ASR_RD_BIT8,
   output logic      LINK_OPEN
);

   cc_state_t  state_ff;
   cc_state_t  nxt_state;
   logic [5:0] ptr_ff;
   logic [5:0] nxt_ptr;
   logic [5:0] cnt_ff;
   logic [5:0] nxt_cnt;
   logic [63:0] snap_ff;
   logic [7:0] stage_ff;
   logic [7:0] hsec_ff;
   logic [7:0] sec_ff;
   logic [7:0] min_ff;
   logic [7:0] hour_ff;
   logic [7:0] dow_ff;
   logic [7:0] dom_ff;
   logic [7:0] month_ff;
   logic [7:0] year_ff;
   logic [63:0] time_all;
   logic [8:0] hsec_step;
   logic [8:0] sec_step;
   logic [8:0] min_step;
   logic [8:0] hour_step;
   logic [8:0] dow_step;
   logic [8:0] dom_step;
   logic [8:0] month_step;
   logic [8:0] year_step;
   logic [7:0] hit;
   logic       sec_en;
   logic       min_en;
   logic       hour_en;
   logic       day_en;
   logic       month_en;
   logic       year_en;
   logic       rd;
   logic       wr;
   logic       tick;
   logic       matched;
   logic       load_snap;
   logic       data_cycle;
   logic       commit;
   logic [2:0] commit_idx;
   logic [7:0] commit_byte;
   logic [7:0] last_day;

   // Hundredths-of-seconds time base.
   cc_tick_gen #(
      .TICK_CYCLES (TICK_CYCLES)
   ) u_tick (
      .CLK     (CLK),
      .SYS_RST (SYS_RST),
      .TICK    (tick)
   );

   // Month length for the day-of-month rollover.
   cc_month_len u_month_len (
      .MONTH    (month_ff),
      .YEAR     (year_ff),
      .LAST_DAY (last_day)
   );

   // A read strobe wins over a write strobe in the same cycle.
   assign rd = ASR_RD_STB;
   assign wr = ASR_WR_STB & ~ASR_RD_STB;

   // Compares the written bit with the pattern bit at the pointer.
   assign matched = (ASR_WR_BIT8 == CC_PATTERN[ptr_ff]); // R3 R4 R5 R6

   // Marks the cycles that move calendar data.
   assign data_cycle = (state_ff == CC_DATA) && (rd || wr); // R9

   // Recognition and transfer sequencing.
   always_comb begin
      nxt_state = state_ff;
      nxt_ptr   = ptr_ff;
      nxt_cnt   = cnt_ff;
      load_snap = 1'b0;
      case (state_ff)
         CC_HUNT: begin
            if (rd) begin
               nxt_ptr = CC_PTR_FIRST; // R1 R8
            end else if (wr) begin
               if (!matched) begin
                  nxt_state = CC_REJECT; // R7
               end else if (ptr_ff == CC_PTR_LAST) begin
                  nxt_state = CC_DATA; // R2
                  nxt_ptr   = CC_PTR_FIRST;
                  nxt_cnt   = CC_PTR_FIRST;
                  load_snap = 1'b1;
               end else begin
                  nxt_ptr = ptr_ff + CC_PTR_STEP; // R6
               end
            end
         end
         CC_REJECT: begin
            if (rd) begin
               nxt_state = CC_HUNT; // R8
               nxt_ptr   = CC_PTR_FIRST; // R1
            end
         end
         CC_DATA: begin
            if (data_cycle) begin
               if (cnt_ff == CC_PTR_LAST) begin
                  nxt_state = CC_HUNT; // R22
                  nxt_ptr   = CC_PTR_FIRST;
                  nxt_cnt   = CC_PTR_FIRST;
               end else begin
                  nxt_cnt = cnt_ff + CC_PTR_STEP; // R9 R10
               end
            end
         end
         default: begin
            nxt_state = CC_HUNT;
            nxt_ptr   = CC_PTR_FIRST;
            nxt_cnt   = CC_PTR_FIRST;
         end
      endcase
   end

   // State register.
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         state_ff <= CC_HUNT;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Comparison pointer.
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         ptr_ff <= CC_PTR_FIRST;
      end else begin
         ptr_ff <= nxt_ptr;
      end
   end

   // Data bit counter.
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         cnt_ff <= CC_PTR_FIRST;
      end else begin
         cnt_ff <= nxt_cnt;
      end
   end

   // Read image: taken when access opens, shifted out bit 0 first.
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         snap_ff <= '0;
      end else if (load_snap) begin
         snap_ff <= time_all; // R10
      end else if (data_cycle && (nxt_state != CC_DATA)) begin
         snap_ff <= '0; // R22
      end else if (data_cycle) begin
         snap_ff <= {1'b0, snap_ff[63:1]}; // R10
      end
   end

   // Write staging byte, filled least significant bit first.
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         stage_ff <= '0;
      end else if ((state_ff == CC_DATA) && wr) begin
         stage_ff <= {ASR_WR_BIT8, stage_ff[7:1]}; // R3
      end
   end

   // A byte is written only when its eighth bit arrives.
   assign commit      = (state_ff == CC_DATA) && wr &&
                        (cnt_ff[2:0] == CC_BYTE_LAST); // R11
   assign commit_idx  = cnt_ff[5:3];
   assign commit_byte = {ASR_WR_BIT8, stage_ff[7:1]};

   // Calendar bytes in access order, register 0 in the low byte.
   assign time_all = {year_ff, month_ff, dom_ff, dow_ff,
                      hour_ff, min_ff, sec_ff, hsec_ff}; // R10

   // One-hot select of the byte that completes this cycle.
   always_comb begin
      for (int i = 0; i < CC_NUM_REGS; i++) begin
         hit[i] = commit && (commit_idx == 3'(i)); // R11
      end
   end

   // A written byte with the reserved bits of its register cleared.
   function automatic logic [7:0] masked_byte(input logic [7:0] b,
                                              input int         idx);
      return b & CC_WMASK[idx];
   endfunction : masked_byte

   // Stepped value and wrap flag of every calendar byte.
   assign hsec_step  = cc_bcd_inc(hsec_ff, CC_MAX[CC_REG_HSEC],
                                  CC_MIN[CC_REG_HSEC]); // R12
   assign sec_step   = cc_bcd_inc(sec_ff, CC_MAX[CC_REG_SEC],
                                  CC_MIN[CC_REG_SEC]); // R13
   assign min_step   = cc_bcd_inc(min_ff, CC_MAX[CC_REG_MIN],
                                  CC_MIN[CC_REG_MIN]); // R14
   assign hour_step  = cc_bcd_inc(hour_ff, CC_MAX[CC_REG_HOUR],
                                  CC_MIN[CC_REG_HOUR]); // R15
   assign dow_step   = cc_bcd_inc(dow_ff, CC_MAX[CC_REG_DOW],
                                  CC_MIN[CC_REG_DOW]); // R16
   assign dom_step   = cc_bcd_inc(dom_ff, last_day,
                                  CC_MIN[CC_REG_DOM]); // R17 R20
   assign month_step = cc_bcd_inc(month_ff, CC_MAX[CC_REG_MONTH],
                                  CC_MIN[CC_REG_MONTH]); // R18
   assign year_step  = cc_bcd_inc(year_ff, CC_MAX[CC_REG_YEAR],
                                  CC_MIN[CC_REG_YEAR]); // R19

   // A byte steps on a tick only when every byte below it wraps, day of week aside: day of month steps when the hours wrap.
   assign sec_en   = tick && hsec_step[8];
   assign min_en   = sec_en && sec_step[8];
   assign hour_en  = min_en && min_step[8];
   assign day_en   = hour_en && hour_step[8]; // R16 R17
   assign month_en = day_en && dom_step[8]; // R20
   assign year_en  = month_en && month_step[8];

   // Hundredths of seconds; a byte written this cycle wins over the tick.
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         hsec_ff <= CC_RESET[CC_REG_HSEC];
      end else if (hit[CC_REG_HSEC]) begin
         hsec_ff <= masked_byte(commit_byte, CC_REG_HSEC); // R11
      end else if (tick) begin
         hsec_ff <= hsec_step[7:0]; // R12
      end
   end

   // Seconds, stepped when the hundredths wrap.
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         sec_ff <= CC_RESET[CC_REG_SEC];
      end else if (hit[CC_REG_SEC]) begin
         sec_ff <= masked_byte(commit_byte, CC_REG_SEC); // R11
      end else if (sec_en) begin
         sec_ff <= sec_step[7:0]; // R13
      end
   end

   // Minutes, stepped when the seconds wrap.
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         min_ff <= CC_RESET[CC_REG_MIN];
      end else if (hit[CC_REG_MIN]) begin
         min_ff <= masked_byte(commit_byte, CC_REG_MIN); // R11
      end else if (min_en) begin
         min_ff <= min_step[7:0]; // R14
      end
   end

   // Hours in 24-hour form, stepped when the minutes wrap.
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         hour_ff <= CC_RESET[CC_REG_HOUR];
      end else if (hit[CC_REG_HOUR]) begin
         hour_ff <= masked_byte(commit_byte, CC_REG_HOUR); // R11
      end else if (hour_en) begin
         hour_ff <= hour_step[7:0]; // R15
      end
   end

   // Day of week, stepped at midnight and wrapping back to one.
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         dow_ff <= CC_RESET[CC_REG_DOW];
      end else if (hit[CC_REG_DOW]) begin
         dow_ff <= masked_byte(commit_byte, CC_REG_DOW); // R11
      end else if (day_en) begin
         dow_ff <= dow_step[7:0]; // R16
      end
   end

   // Day of month, wrapping after the last day of the current month.
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         dom_ff <= CC_RESET[CC_REG_DOM];
      end else if (hit[CC_REG_DOM]) begin
         dom_ff <= masked_byte(commit_byte, CC_REG_DOM); // R11
      end else if (day_en) begin
         dom_ff <= dom_step[7:0]; // R17 R20
      end
   end

   // Month, stepped when the day of month wraps.
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         month_ff <= CC_RESET[CC_REG_MONTH];
      end else if (hit[CC_REG_MONTH]) begin
         month_ff <= masked_byte(commit_byte, CC_REG_MONTH); // R11
      end else if (month_en) begin
         month_ff <= month_step[7:0]; // R18
      end
   end

   // Year, stepped when the month wraps; there is no century rule.
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         year_ff <= CC_RESET[CC_REG_YEAR];
      end else if (hit[CC_REG_YEAR]) begin
         year_ff <= masked_byte(commit_byte, CC_REG_YEAR); // R11
      end else if (year_en) begin
         year_ff <= year_step[7:0]; // R19
      end
   end

   // Bit 8 read value; zero whenever no data access is open.
   assign ASR_RD_BIT8 = snap_ff[0]; // R21
   assign LINK_OPEN   = (state_ff == CC_DATA);

endmodule : cc_calendar_clock

// file: design/cc_month_len.sv
// Last day of the month in BCD, with February stretched in leap years.
`timescale 1ns/1ps
module cc_month_len
   import cc_pkg::*;
(
   input  wire logic [7:0] MONTH,
   input  wire logic [7:0] YEAR,
   output logic      [7:0] LAST_DAY
);

   logic leap;

   // A two-digit BCD year is a leap year when divisible by four.
   always_comb begin
      if (YEAR[4]) begin
         leap = (YEAR[3:0] == 4'h2) || (YEAR[3:0] == 4'h6);
      end else begin
         leap = (YEAR[3:0] == 4'h0) || (YEAR[3:0] == 4'h4) ||
                (YEAR[3:0] == 4'h8);
      end
   end

   // Picks the month length.
   always_comb begin
      case (MONTH)
         CC_MON_FEB: LAST_DAY = leap ? CC_DAYS_29 : CC_DAYS_28; // R20
         CC_MON_APR,
         CC_MON_JUN,
         CC_MON_SEP,
         CC_MON_NOV: LAST_DAY = CC_DAYS_30; // R20
         default:    LAST_DAY = CC_DAYS_31;
      endcase
   end

endmodule : cc_month_len

// file: design/cc_pkg.sv
// Shared constants, types and functions for the calendar clock serial port.
package cc_pkg;

   // Timing of the hundredths-of-seconds tick.
   localparam int CC_CLK_PERIOD_NS  = 40;
   localparam int CC_TICK_PERIOD_NS = 10_000_000;
   localparam int CC_TICK_CYCLES    = CC_TICK_PERIOD_NS / CC_CLK_PERIOD_NS;
   localparam int CC_TICK_CNT_W     = 18;

   // Recognition pattern words, sent first word first, bit 0 first.
   localparam logic [15:0] CC_WORD_A  = 16'h3AC5; // Octal 035305.
   localparam logic [15:0] CC_WORD_B  = 16'h5CA3; // Octal 056243.
   localparam logic [63:0] CC_PATTERN = {CC_WORD_B, CC_WORD_A,
                                         CC_WORD_B, CC_WORD_A};

   // Bit positions in the 64-bit streams.
   localparam logic [5:0] CC_PTR_FIRST = 6'h00;
   localparam logic [5:0] CC_PTR_LAST  = 6'h3F;
   localparam logic [5:0] CC_PTR_STEP  = 6'h01;
   localparam logic [2:0] CC_BYTE_LAST = 3'h7;

   // Calendar register indices.
   localparam int CC_REG_HSEC  = 0;
   localparam int CC_REG_SEC   = 1;
   localparam int CC_REG_MIN   = 2;
   localparam int CC_REG_HOUR  = 3;
   localparam int CC_REG_DOW   = 4;
   localparam int CC_REG_DOM   = 5;
   localparam int CC_REG_MONTH = 6;
   localparam int CC_REG_YEAR  = 7;
   localparam int CC_NUM_REGS  = 8;

   // Writable bits of each register; reserved bits are forced to zero.
   localparam logic [7:0] CC_WMASK [0:7] = '{8'hFF, 8'h7F, 8'h7F, 8'h3F,
                                             8'h07, 8'h3F, 8'h1F, 8'hFF};
   // Power-up values: midnight, day 1, the first of January, year 00.
   localparam logic [7:0] CC_RESET [0:7] = '{8'h00, 8'h00, 8'h00, 8'h00,
                                             8'h01, 8'h01, 8'h01, 8'h00};
   // Highest and lowest BCD value of each register.
   localparam logic [7:0] CC_MAX [0:7]   = '{8'h99, 8'h59, 8'h59, 8'h23,
                                             8'h07, 8'h31, 8'h12, 8'h99};
   localparam logic [7:0] CC_MIN [0:7]   = '{8'h00, 8'h00, 8'h00, 8'h00,
                                             8'h01, 8'h01, 8'h01, 8'h00};

   // BCD digit values.
   localparam logic [3:0] CC_DIGIT_ZERO = 4'h0;
   localparam logic [3:0] CC_DIGIT_ONE  = 4'h1;
   localparam logic [3:0] CC_DIGIT_NINE = 4'h9;

   // Month codes and month lengths in BCD.
   localparam logic [7:0] CC_MON_FEB  = 8'h02;
   localparam logic [7:0] CC_MON_APR  = 8'h04;
   localparam logic [7:0] CC_MON_JUN  = 8'h06;
   localparam logic [7:0] CC_MON_SEP  = 8'h09;
   localparam logic [7:0] CC_MON_NOV  = 8'h11;
   localparam logic [7:0] CC_DAYS_28  = 8'h28;
   localparam logic [7:0] CC_DAYS_29  = 8'h29;
   localparam logic [7:0] CC_DAYS_30  = 8'h30;
   localparam logic [7:0] CC_DAYS_31  = 8'h31;

   // Recognition and transfer states.
   typedef enum logic [1:0] {CC_HUNT, CC_REJECT, CC_DATA} cc_state_t;

   // Steps a BCD byte by one; wraps to the minimum and flags a carry.
   function automatic logic [8:0] cc_bcd_inc(input logic [7:0] v,
                                             input logic [7:0] max,
                                             input logic [7:0] min);
      logic [8:0] r;
      r = {1'b0, v};
      if (v >= max) begin
         r = {1'b1, min};
      end else if (v[3:0] >= CC_DIGIT_NINE) begin
         r = {1'b0, v[7:4] + CC_DIGIT_ONE, CC_DIGIT_ZERO};
      end else begin
         r = {1'b0, v[7:4], v[3:0] + CC_DIGIT_ONE};
      end
      return r;
   endfunction : cc_bcd_inc

endpackage : cc_pkg

// file: design/cc_tick_gen.sv
// Prescaler that makes one pulse every hundredth of a second.
`timescale 1ns/1ps
module cc_tick_gen
   import cc_pkg::*;
#(
   parameter int TICK_CYCLES = CC_TICK_CYCLES
) (
   input  wire logic CLK,
   input  wire logic SYS_RST,
   output logic      TICK
);

   localparam logic [CC_TICK_CNT_W-1:0] TERM =
      CC_TICK_CNT_W'(TICK_CYCLES - 1);
   localparam logic [CC_TICK_CNT_W-1:0] ZERO = '0;
   localparam logic [CC_TICK_CNT_W-1:0] ONE  = CC_TICK_CNT_W'(1);

   logic [CC_TICK_CNT_W-1:0] cnt_ff;
   logic                     tick_ff;

   // Counts clock cycles and pulses once per full period.
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         cnt_ff  <= ZERO;
         tick_ff <= 1'b0;
      end else if (cnt_ff >= TERM) begin
         cnt_ff  <= ZERO;
         tick_ff <= 1'b1;
      end else begin
         cnt_ff  <= cnt_ff + ONE;
         tick_ff <= 1'b0;
      end
   end

   assign TICK = tick_ff;

endmodule : cc_tick_gen

// file: sim/calendar_clock_serial_port_tb.sv
// Self-checking testbench for the serial calendar clock port.
`timescale 1ns/1ps
module calendar_clock_serial_port_tb;
   import cc_pkg::*;
   localparam int TICKS = 20000;
   logic        CLK;
   logic        SYS_RST;
   logic        rd_stb;
   logic        wr_stb;
   logic        wr_bit8;
   logic        rd_bit8;
   logic        link_open;
   logic [63:0] img;
   int          n_mismatch;
   int          n_checks;

   // Free-running 25 MHz clock.
   initial CLK = 1'b0;
   always #20 CLK = ~CLK;

   cc_calendar_clock #(.TICK_CYCLES(TICKS)) u_dut (
      .CLK         (CLK),
      .SYS_RST     (SYS_RST),
      .ASR_RD_STB  (rd_stb),
      .ASR_WR_STB  (wr_stb),
      .ASR_WR_BIT8 (wr_bit8),
      .ASR_RD_BIT8 (rd_bit8),
      .LINK_OPEN   (link_open)
   );

   cc_host_model u_host (
      .CLK     (CLK),
      .RD_BIT8 (rd_bit8),
      .RD_STB  (rd_stb),
      .WR_STB  (wr_stb),
      .WR_BIT8 (wr_bit8)
   );

   // Prints the verdict and ends the run.
   task automatic summarize();
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : summarize

   // Compares a seen value with the expected one.
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   // Opens the link, then moves all 64 data bits in one direction.
   task automatic xfer(input logic wr, input logic [63:0] wv,
                       output logic [63:0] rv);
      u_host.open();
      chk({63'h0, link_open}, 64'h0000_0000_0000_0001);
      for (int i = 0; i < 64; i++) begin
         u_host.cyc(!wr, wv[i], rv[i]);
      end
      chk({63'h0, link_open}, 64'h0000_0000_0000_0000);
   endtask : xfer

   // Power-up calendar image read over a fresh link.
   task automatic t_reset_image();
      xfer(1'b0, 64'h0000_0000_0000_0000, img);
      chk(img, 64'h0001_0101_0000_0000);
   endtask : t_reset_image

   // Bad first bit, ignored writes, then a read that restarts matching.
   task automatic t_refuse();
      logic q;
      u_host.cyc(1'b1, 1'b0, q);
      for (int i = 0; i < 84; i++) begin
         u_host.cyc(1'b0, CC_PATTERN[i % 64] ^ (i == 0), q);
      end
      chk({63'h0, link_open}, 64'h0000_0000_0000_0000);
      u_host.cyc(1'b1, 1'b0, q);
      for (int i = 0; i < 20; i++) begin
         u_host.cyc(1'b0, CC_PATTERN[i], q);
      end
      u_host.cyc(1'b1, 1'b0, q);
      for (int i = 0; i < 64; i++) begin
         u_host.cyc(1'b0, CC_PATTERN[i], q);
      end
      chk({63'h0, link_open}, 64'h0000_0000_0000_0001);
      for (int i = 0; i < 64; i++) begin
         u_host.cyc(1'b1, 1'b0, img[i]);
      end
      chk(img, 64'h0001_0101_0000_0000);
   endtask : t_refuse

   // All ones written; reserved bits must read back as zero.
   task automatic t_masks();
      xfer(1'b1, 64'hFFFF_FFFF_FFFF_FFFF, img);
      xfer(1'b0, 64'h0000_0000_0000_0000, img);
      chk(img, 64'hFF1F_3F07_3F7F_7FFF);
   endtask : t_masks

   // Sets a value one tick before midnight and reads it after one tick.
   task automatic t_roll(input logic [63:0] wv, input logic [63:0] ev);
      xfer(1'b1, wv, img);
      repeat (TICKS) @(posedge CLK);
      #1;
      xfer(1'b0, 64'h0000_0000_0000_0000, img);
      chk(img, ev);
   endtask : t_roll

   // Main sequence.
   initial begin
      n_mismatch = 0;
      n_checks = 0;
      SYS_RST = 1'b1;
      repeat (6) @(posedge CLK);
      #1;
      SYS_RST = 1'b0;
      t_reset_image();
      t_refuse();
      t_masks();
      t_roll(64'h2302_2807_2359_5999, 64'h2303_0101_0000_0000);
      t_roll(64'h2402_2803_2359_5999, 64'h2402_2904_0000_0000);
      t_roll(64'h2404_3005_2359_5999, 64'h2405_0106_0000_0000);
      summarize();
   end

   // Cuts a hang short.
   initial begin
      repeat (80000) @(posedge CLK);
      n_mismatch++;
      summarize();
   end
endmodule : calendar_clock_serial_port_tb

// file: sim/cc_host_model.sv
// Bus master model that issues read and write cycles to bit 8.
`timescale 1ns/1ps
module cc_host_model
   import cc_pkg::*;
(
   input  wire logic CLK,
   input  wire logic RD_BIT8,
   output logic      RD_STB,
   output logic      WR_STB,
   output logic      WR_BIT8
);
   // Bus idle at time zero.
   initial begin
      RD_STB = 1'b0;
      WR_STB = 1'b0;
      WR_BIT8 = 1'b0;
   end

   // One bus cycle carrying one bit; the data line flips on release.
   task automatic cyc(input logic is_rd, input logic b, output logic q);
      q = RD_BIT8;
      RD_STB = is_rd;
      WR_STB = !is_rd;
      WR_BIT8 = b;
      @(posedge CLK);
      #1;
      RD_STB = 1'b0;
      WR_STB = 1'b0;
      WR_BIT8 = ~b;
      @(posedge CLK);
      #1;
   endtask : cyc

   // Clears the pointer, then sends the pattern bit 0 first.
   task automatic open();
      logic q;
      cyc(1'b1, 1'b0, q);
      for (int i = 0; i < 64; i++) begin
         cyc(1'b0, CC_PATTERN[i], q);
      end
   endtask : open
endmodule : cc_host_model

// file: sim/cc_port_monitor.sv
// Concurrent checks on the serial calendar clock port.
`timescale 1ns/1ps
module cc_port_monitor
   import cc_pkg::*;
(
   input wire logic CLK,
   input wire logic SYS_RST,
   input wire logic ASR_RD_STB,
   input wire logic ASR_WR_STB,
   input wire logic ASR_WR_BIT8,
   input wire logic ASR_RD_BIT8,
   input wire logic LINK_OPEN
);
   logic [5:0] cnt_ff;
   logic [6:0] good_ff;
   logic       rej_ff;
   logic       stb;

   default clocking cb @(posedge CLK); endclocking
   default disable iff (SYS_RST);

   // Any bus cycle.
   assign stb = ASR_RD_STB || ASR_WR_STB;

   // Counts data cycles while the link is open.
   always_ff @(posedge CLK) begin
      if (SYS_RST || !LINK_OPEN) begin
         cnt_ff <= 6'h00;
      end else if (stb) begin
         cnt_ff <= cnt_ff + 6'h01;
      end
   end

   // Counts matching pattern writes since the last clearing read.
   always_ff @(posedge CLK) begin
      if (SYS_RST || LINK_OPEN || ASR_RD_STB) begin
         good_ff <= 7'h00;
         rej_ff <= 1'b0;
      end else if (ASR_WR_STB && !rej_ff) begin
         if (ASR_WR_BIT8 == CC_PATTERN[good_ff[5:0]]) begin
            good_ff <= good_ff + 7'h01;
         end else begin
            rej_ff <= 1'b1;
         end
      end
   end

   sequence s_last_data;
      LINK_OPEN && stb && cnt_ff == 6'h3F;
   endsequence
   sequence s_last_pat;
      !LINK_OPEN && ASR_WR_STB && !ASR_RD_STB && !rej_ff &&
      good_ff == 7'h3F && ASR_WR_BIT8 == CC_PATTERN[63];
   endsequence

   property p_close;
      s_last_data |=> !LINK_OPEN && !ASR_RD_BIT8;
   endproperty
   property p_hold;
      LINK_OPEN && !(stb && cnt_ff == 6'h3F) |=> LINK_OPEN;
   endproperty
   property p_open;
      s_last_pat |=> LINK_OPEN;
   endproperty
   property p_match;
      $rose(LINK_OPEN) |-> good_ff == 7'h40 && $past(ASR_WR_STB);
   endproperty
   property p_abort;
      !LINK_OPEN && ASR_RD_STB |=> !LINK_OPEN [*8];
   endproperty
   property p_reject;
      rej_ff && !ASR_RD_STB |=> !LINK_OPEN;
   endproperty
   property p_quiet;
      !LINK_OPEN |-> !ASR_RD_BIT8;
   endproperty
   property p_stable;
      LINK_OPEN && !stb |=> $stable(ASR_RD_BIT8);
   endproperty
   property p_reset;
      disable iff (1'b0) SYS_RST |=> !LINK_OPEN && !ASR_RD_BIT8;
   endproperty

   a_close: assert property (p_close)
      else $error("link stayed open after the last data cycle");
   a_hold: assert property (p_hold)
      else $error("link closed before the last data cycle");
   a_open: assert property (p_open)
      else $error("link did not open after the full pattern");
   a_match: assert property (p_match)
      else $error("link opened without a full matching pattern");
   a_abort: assert property (p_abort)
      else $error("link opened too soon after a clearing read");
   a_reject: assert property (p_reject)
      else $error("link opened after a mismatching write");
   a_quiet: assert property (p_quiet)
      else $error("data bit driven outside the data phase");
   a_stable: assert property (p_stable)
      else $error("data bit moved without a bus cycle");
   a_reset: assert property (p_reset)
      else $error("outputs not cleared by reset");
endmodule : cc_port_monitor

bind cc_calendar_clock cc_port_monitor u_mon (
   .CLK         (CLK),
   .SYS_RST     (SYS_RST),
   .ASR_RD_STB  (ASR_RD_STB),
   .ASR_WR_STB  (ASR_WR_STB),
   .ASR_WR_BIT8 (ASR_WR_BIT8),
   .ASR_RD_BIT8 (ASR_RD_BIT8),
   .LINK_OPEN   (LINK_OPEN)
);
